// ---- verilog/async_mem_map.vh ----
// Register offsets, field positions, reset values and timing counts
// Assumes an AXI4-Lite register port with 32-bit data on a 50 MHz clock
// Function
// RULE1: Type 000b is 8-bit, 001b is 16-bit
// RULE2: Timing ignored unless space type is asynchronous
// RULE3: One global bit enables write posting everywhere; the code never posts DMA writes
// RULE4: Ready ignore set means no sampling, no time-out
// RULE5: Setup fields give cycles before strobe falls
// RULE6: Strobe fields give cycles strobe stays low
// RULE7: Hold fields give cycles after strobe rises
// RULE8: Extended hold on space or direction change
// RULE9: Extended hold equals programmed count plus one
// RULE10: Count ready-low cycles, one shared time-out
// RULE11: Time-out records error in bus error status
// RULE12: Time-out interrupts CPU or signals DMA
// RULE13: Setup 0..2 gives 2 first, 1 later
// RULE14: Ready stretches strobe only if strobe >= 4; the code stretches read strobes only
// RULE15: Read data captured at end of strobe
// RULE16: Ready-low counter clears at each access start
`ifndef ASYNC_MEM_MAP_VH
`define ASYNC_MEM_MAP_VH
`define REG_GLOBAL 8'h00
`define REG_STATUS 8'h04
`define REG_MASK 8'h08
`define REG_TIMEOUT 8'h0C
`define REG_BUSERR 8'h10
`define REG_SPACE_BASE 8'h20
`define REG_SPACE_STEP 8'h04
`define GBL_WPE_BIT 0
`define GBL_RDY_IGN_BIT 1
`define MEMORY_TYPE_SEL_LSB 0
`define RDSET_LSB 4
`define RDSTB_LSB 8
`define RDHLD_LSB 14
`define RDEXH_LSB 16
`define WRSET_LSB 18
`define WRSTB_LSB 22
`define WRHLD_LSB 28
`define WREXH_LSB 30
`define MEMORY_TYPE_SEL_8BIT 3'h0
`define MEMORY_TYPE_SEL_16BIT 3'h1
`define SPACE_RESET 32'hFFFFFFF1
`define TIMEOUT_RESET 8'hFF
`define SETUP_MIN_FIRST 4'h2
`define SETUP_MIN_NEXT 4'h1
`define SETUP_LOW_MAX 4'h2
`define STROBE_RDY_MIN 6'h04
`define ST_EV_TIMEOUT 0
`define ST_EV_WIDTH_ERR 1
`endif

// ---- verilog/cycle_counter.v ----
// Down counter that times one phase of an external access
// Assumes load and the count value come from the same clock domain
`timescale 1ns/1ps
module cycle_counter #(
  parameter W = 6
) (
  input wire aclk,
  input wire aresetn,
  input wire load,
  input wire [W-1:0] value,
  input wire hold,
  output wire done
);
  reg [W-1:0] cnt_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= {W{1'b0}};
    end else if (load) begin
      cnt_q <= value;
    end else if (!hold && cnt_q != {W{1'b0}}) begin
      cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
    end
  end
  assign done = (cnt_q <= {{(W-1){1'b0}}, 1'b1}) && !hold;
endmodule // cycle_counter

// ---- verilog/async_mem_ctrl.v ----
// Asynchronous memory access controller with AXI4-Lite configuration
// Assumes one requester at a time holding req until ack; mem_ready_in is a raw pin
`timescale 1ns/1ps
`include "async_mem_map.vh"
module async_mem_ctrl #(
  parameter SPACES = 4,
  parameter AW = 21
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire req,
  input wire req_write,
  input wire req_dma,
  input wire [1:0] req_space,
  input wire [AW-1:0] req_addr,
  input wire [15:0] req_wdata,
  input wire [1:0] req_byte_en,
  output wire ack,
  output reg [15:0] rdata_q,
  output reg dma_timeout,
  output wire irq,
  output reg [3:0] chip_en_n,
  output reg [AW-1:0] mem_addr,
  output reg [1:0] byte_lane_n,
  output reg output_en_n,
  output reg read_strobe_n,
  output reg write_strobe_n,
  output reg [15:0] mem_dout,
  output reg mem_dout_en,
  input wire [15:0] mem_din,
  input wire mem_ready_in
);
  localparam S_IDLE = 3'd0;
  localparam S_SETUP = 3'd1;
  localparam S_STROBE = 3'd2;
  localparam S_HOLD = 3'd3;
  localparam S_EXHOLD = 3'd4;
  localparam S_DONE = 3'd5;

  reg [31:0] global_q;
  reg [31:0] space_q [0:SPACES-1];
  reg [1:0] status_q;
  reg [1:0] mask_q;
  reg [7:0] tmo_q;
  reg [31:0] buserr_q;
  reg aw_hold_q;
  reg w_hold_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg early_ack_q;
  reg [2:0] state_q;
  reg active_q;
  reg last_write_q;
  reg [1:0] last_space_q;
  reg cur_write_q;
  reg cur_dma_q;
  reg [1:0] cur_space_q;
  reg [7:0] rdy_cnt_q;
  reg rdy_s1_q;
  reg rdy_s2_q;
  reg ev_tmo;
  reg ev_width;
  reg load;
  reg [5:0] load_val;
  integer i;

  wire [31:0] cfg = space_q[req_space];
  wire [31:0] cur_cfg = space_q[cur_space_q];
  wire is_async = cfg[`MEMORY_TYPE_SEL_LSB+2:`MEMORY_TYPE_SEL_LSB] == `MEMORY_TYPE_SEL_8BIT ||
    cfg[`MEMORY_TYPE_SEL_LSB+2:`MEMORY_TYPE_SEL_LSB] == `MEMORY_TYPE_SEL_16BIT; // RULE1
  wire bad_width = cfg[`MEMORY_TYPE_SEL_LSB+2:`MEMORY_TYPE_SEL_LSB] == `MEMORY_TYPE_SEL_8BIT && req_write; // RULE1
  wire same = active_q && last_space_q == req_space && last_write_q == req_write;
  wire [3:0] set_raw = req_write ? cfg[`WRSET_LSB+3:`WRSET_LSB] :
    cfg[`RDSET_LSB+3:`RDSET_LSB];
  wire [3:0] set_cyc = (set_raw > `SETUP_LOW_MAX) ? set_raw :
    (same ? `SETUP_MIN_NEXT : `SETUP_MIN_FIRST); // RULE13
  wire [5:0] stb_cyc = cur_write_q ? cur_cfg[`WRSTB_LSB+5:`WRSTB_LSB] :
    cur_cfg[`RDSTB_LSB+5:`RDSTB_LSB]; // RULE6
  wire [1:0] hld_cyc = cur_write_q ? cur_cfg[`WRHLD_LSB+1:`WRHLD_LSB] :
    cur_cfg[`RDHLD_LSB+1:`RDHLD_LSB]; // RULE7
  wire [1:0] exh_cyc = last_write_q ? space_q[last_space_q][`WREXH_LSB+1:`WREXH_LSB] :
    space_q[last_space_q][`RDEXH_LSB+1:`RDEXH_LSB];
  wire rdy_use = !global_q[`GBL_RDY_IGN_BIT]; // RULE4
  wire rdy_low = rdy_use && !rdy_s2_q;
  wire stretch = rdy_low && !cur_write_q && stb_cyc >= `STROBE_RDY_MIN; // RULE14
  wire timed_out = rdy_low && rdy_cnt_q + 8'h01 >= tmo_q; // RULE10
  wire phase_done;
  wire posted = global_q[`GBL_WPE_BIT] && req_write && !req_dma; // RULE3

  cycle_counter #(.W(6)) phase_cnt (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(load),
    .value(load_val),
    .hold(state_q == S_STROBE && stretch),
    .done(phase_done)
  );

  assign ack = (state_q == S_DONE && !early_ack_q) ||
    (state_q == S_SETUP && cur_write_q && posted && load); // RULE3

  // Ready pin synchroniser
  always @(posedge aclk) begin
    if (!aresetn) begin
      rdy_s1_q <= 1'b1;
      rdy_s2_q <= 1'b1;
    end else begin
      rdy_s1_q <= mem_ready_in;
      rdy_s2_q <= rdy_s1_q;
    end
  end

  // Phase sequencer
  always @* begin
    load = 1'b0;
    load_val = 6'h00;
    case (state_q)
      S_IDLE: begin
        if (req && is_async && !bad_width && active_q && !same) begin
          load = 1'b1;
          load_val = {4'h0, exh_cyc} + 6'h01; // RULE9
        end else if (req && is_async && !bad_width) begin
          load = 1'b1;
          load_val = {2'h0, set_cyc}; // RULE5
        end
      end
      S_EXHOLD: begin
        if (phase_done) begin
          load = 1'b1;
          load_val = {2'h0, set_cyc};
        end
      end
      S_SETUP: begin
        if (phase_done) begin
          load = 1'b1;
          load_val = stb_cyc;
        end
      end
      S_STROBE: begin
        if (phase_done) begin
          load = 1'b1;
          load_val = {4'h0, hld_cyc};
        end
      end
      default: begin
        load = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= S_IDLE;
      active_q <= 1'b0;
      last_write_q <= 1'b0;
      last_space_q <= 2'h0;
      cur_write_q <= 1'b0;
      cur_dma_q <= 1'b0;
      cur_space_q <= 2'h0;
      rdy_cnt_q <= 8'h00;
      rdata_q <= 16'h0000;
      dma_timeout <= 1'b0;
      chip_en_n <= 4'hF;
      mem_addr <= {AW{1'b0}};
      byte_lane_n <= 2'h3;
      output_en_n <= 1'b1;
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      mem_dout <= 16'h0000;
      mem_dout_en <= 1'b0;
      ev_tmo <= 1'b0;
      ev_width <= 1'b0;
      early_ack_q <= 1'b0;
    end else begin
      ev_tmo <= 1'b0;
      ev_width <= 1'b0;
      dma_timeout <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (req && !is_async) begin
            state_q <= S_DONE; // RULE2
          end else if (req && bad_width) begin
            ev_width <= 1'b1;
            state_q <= S_DONE;
          end else if (load && active_q && !same) begin
            chip_en_n <= 4'hF; // RULE8
            output_en_n <= 1'b1;
            byte_lane_n <= 2'h3;
            state_q <= S_EXHOLD;
          end else if (load) begin
            state_q <= S_SETUP;
            cur_write_q <= req_write;
            cur_dma_q <= req_dma;
            cur_space_q <= req_space;
            rdy_cnt_q <= 8'h00; // RULE16
            chip_en_n <= ~(4'h1 << req_space); // RULE5
            mem_addr <= req_addr;
            byte_lane_n <= ~req_byte_en;
            output_en_n <= req_write;
            mem_dout <= req_wdata;
            mem_dout_en <= req_write;
          end
        end
        S_EXHOLD: begin
          if (load) begin
            active_q <= 1'b0;
            state_q <= S_SETUP;
            cur_write_q <= req_write;
            cur_dma_q <= req_dma;
            cur_space_q <= req_space;
            rdy_cnt_q <= 8'h00; // RULE16
            chip_en_n <= ~(4'h1 << req_space);
            mem_addr <= req_addr;
            byte_lane_n <= ~req_byte_en;
            output_en_n <= req_write;
            mem_dout <= req_wdata;
            mem_dout_en <= req_write;
          end
        end
        S_SETUP: begin
          if (load) begin
            early_ack_q <= ack; // RULE3
            state_q <= S_STROBE;
            read_strobe_n <= cur_write_q;
            write_strobe_n <= !cur_write_q;
          end
        end
        S_STROBE: begin
          if (rdy_low && !timed_out && rdy_cnt_q != 8'hFF) begin
            rdy_cnt_q <= rdy_cnt_q + 8'h01; // RULE10
          end
          if (timed_out && rdy_cnt_q != 8'hFF) begin
            rdy_cnt_q <= 8'hFF;
            ev_tmo <= !cur_dma_q; // RULE12
            dma_timeout <= cur_dma_q; // RULE12
          end
          if (load) begin
            if (!cur_write_q) begin
              rdata_q <= mem_din; // RULE15
            end
            read_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
            state_q <= S_HOLD;
          end
        end
        S_HOLD: begin
          if (phase_done) begin
            active_q <= 1'b1;
            last_write_q <= cur_write_q;
            last_space_q <= cur_space_q;
            mem_dout_en <= 1'b0;
            state_q <= S_DONE;
          end
        end
        default: begin
          early_ack_q <= 1'b0;
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // AXI4-Lite register slave
  wire aw_ok = aw_hold_q || s_axi_awvalid;
  wire w_ok = w_hold_q || s_axi_wvalid;
  wire [7:0] waddr = aw_hold_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wdata = w_hold_q ? wdata_q : s_axi_wdata;
  wire do_write = aw_ok && w_ok && !s_axi_bvalid;
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign irq = |(status_q & mask_q);
  wire wsp = waddr >= `REG_SPACE_BASE &&
    waddr < `REG_SPACE_BASE + SPACES * `REG_SPACE_STEP;
  wire [7:0] wsp_off = waddr - `REG_SPACE_BASE;
  wire [7:0] rsp_off = s_axi_araddr - `REG_SPACE_BASE;
  wire berr_ev = ev_tmo || ev_width || dma_timeout;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h00000000;
      global_q <= 32'h00000000;
      status_q <= 2'h0;
      mask_q <= 2'h0;
      tmo_q <= `TIMEOUT_RESET;
      buserr_q <= 32'h00000000;
      for (i = 0; i < SPACES; i = i + 1) begin
        space_q[i] <= `SPACE_RESET;
      end
    end else begin
      if (s_axi_awvalid && s_axi_awready && !do_write) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready && !do_write) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      status_q <= status_q | {ev_width, ev_tmo};
      if (berr_ev) begin
        buserr_q <= {29'h0, cur_dma_q, ev_width, ev_tmo || dma_timeout}; // RULE11
      end
      if (do_write) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        if (waddr == `REG_GLOBAL) begin
          global_q <= {30'h0, wdata[1:0]};
        end else if (waddr == `REG_STATUS) begin
          status_q <= (status_q & ~wdata[1:0]) | {ev_width, ev_tmo};
        end else if (waddr == `REG_MASK) begin
          mask_q <= wdata[1:0];
        end else if (waddr == `REG_TIMEOUT) begin
          tmo_q <= wdata[7:0];
        end else if (waddr == `REG_BUSERR) begin
          if (!berr_ev) begin
            buserr_q <= 32'h00000000;
          end
        end else if (wsp && waddr[1:0] == 2'h0) begin
          space_q[wsp_off[3:2]] <= wdata;
        end else begin
          s_axi_bresp <= 2'h2;
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        if (s_axi_araddr == `REG_GLOBAL) begin
          s_axi_rdata <= global_q;
        end else if (s_axi_araddr == `REG_STATUS) begin
          s_axi_rdata <= {30'h0, status_q};
        end else if (s_axi_araddr == `REG_MASK) begin
          s_axi_rdata <= {30'h0, mask_q};
        end else if (s_axi_araddr == `REG_TIMEOUT) begin
          s_axi_rdata <= {24'h0, tmo_q};
        end else if (s_axi_araddr == `REG_BUSERR) begin
          s_axi_rdata <= buserr_q;
        end else if (s_axi_araddr >= `REG_SPACE_BASE &&
          s_axi_araddr < `REG_SPACE_BASE + SPACES * `REG_SPACE_STEP) begin
          s_axi_rdata <= space_q[rsp_off[3:2]];
        end else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'h2;
        end
      end
    end
  end
endmodule // async_mem_ctrl

// ---- bench/async_mem_ctrl_checker.sv ----
// Concurrent checks on the external memory pins, read data and DMA time-out of the access controller
// Assumes a bind into async_mem_ctrl; one clock aclk, synchronous active-low aresetn
`timescale 1ns/1ps
module async_mem_ctrl_checker (
  input wire aclk,
  input wire aresetn,
  input wire [15:0] rdata_q,
  input wire dma_timeout,
  input wire [3:0] chip_en_n,
  input wire output_en_n,
  input wire read_strobe_n,
  input wire write_strobe_n,
  input wire mem_dout_en,
  input wire [15:0] mem_din
);
  wire [7:0] din_lo = mem_din[7:0];
  wire ce_on = chip_en_n != 4'hF;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_rd_oe_low: assert property (!read_strobe_n |-> !output_en_n && write_strobe_n)
    else $error("read strobe low without output enable");
  a_wr_drive_on: assert property (!write_strobe_n |-> mem_dout_en && output_en_n)
    else $error("write strobe low without data drive");
  a_wr_setup_ok: assert property ($fell(write_strobe_n) |-> $past(mem_dout_en) && $past(ce_on))
    else $error("write strobe fell without setup");
  a_rd_setup_ok: assert property ($fell(read_strobe_n) |-> !$past(output_en_n) && $past(ce_on))
    else $error("read strobe fell without setup");
  a_rd_hold_oe: assert property ($rose(read_strobe_n) |-> !output_en_n && ce_on)
    else $error("output enable dropped with read strobe");
  a_wr_hold_ce: assert property ($rose(write_strobe_n) |-> ce_on)
    else $error("chip enable dropped with write strobe");
  a_space_change: assert property (ce_on && $past(ce_on) |-> chip_en_n == $past(chip_en_n))
    else $error("space change without idle chip enables");
  a_rd_capture: assert property ($rose(read_strobe_n) |-> rdata_q[7:0] == $past(din_lo))
    else $error("read data not captured at strobe end");
  a_dma_pulse: assert property ($rose(dma_timeout) |=> !dma_timeout)
    else $error("dma time-out longer than one cycle");
endmodule // async_mem_ctrl_checker
bind async_mem_ctrl async_mem_ctrl_checker checker_inst (.aclk(aclk), .aresetn(aresetn),
  .rdata_q(rdata_q), .dma_timeout(dma_timeout), .chip_en_n(chip_en_n),
  .output_en_n(output_en_n), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
  .mem_dout_en(mem_dout_en), .mem_din(mem_din));

// ---- bench/async_mem_model.sv ----
// Behavioural asynchronous 16-bit memory with a ready output that can stall reads
// Assumes the controller pins; stall sets how many strobe cycles ready stays low
`timescale 1ns/1ps
module async_mem_model (
  input wire aclk,
  input wire [3:0] chip_en_n,
  input wire [20:0] mem_addr,
  input wire [1:0] byte_lane_n,
  input wire output_en_n,
  input wire read_strobe_n,
  input wire write_strobe_n,
  input wire [15:0] mem_dout,
  input wire mem_dout_en,
  input wire [7:0] stall,
  output wire [15:0] mem_din,
  output wire mem_ready_in
);
  logic [15:0] mem [0:15];
  logic [15:0] last = 16'h0000;
  logic [7:0] cnt = 8'h00;
  wire sel = chip_en_n != 4'hF;
  wire drive = sel && !output_en_n;
  // Released bus shows the inverse of the last value
  assign mem_din = drive ? mem[mem_addr[3:0]] : ~last;
  // Ready held low only for the stall count of a read strobe
  assign mem_ready_in = !(!read_strobe_n && cnt < stall);
  always @(posedge aclk) begin
    if (drive)
      last <= mem[mem_addr[3:0]];
    if (read_strobe_n)
      cnt <= 8'h00;
    else if (cnt != 8'hFF)
      cnt <= cnt + 8'h01;
    if (sel && !write_strobe_n && mem_dout_en && !byte_lane_n[0])
      mem[mem_addr[3:0]][7:0] <= mem_dout[7:0];
    if (sel && !write_strobe_n && mem_dout_en && !byte_lane_n[1])
      mem[mem_addr[3:0]][15:8] <= mem_dout[15:8];
  end
endmodule // async_mem_model

// ---- bench/testbench.sv ----
// Self-checking bench: register access over AXI4-Lite and memory requests
// Assumes async_mem_ctrl with the memory model on its pins
`timescale 1ns/1ps
module testbench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, stall = 8'h00;
  logic [31:0] wdata = 32'h0, d, l1, l2, n, rcnt = 0, rwid = 0, wcnt = 0, wwid = 0, nfall = 0;
  logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0, rs_q = 1'b1;
  logic req = 1'b0, req_write = 1'b0, req_dma = 1'b0;
  logic [1:0] req_space = 2'h0, r;
  logic [31:0] ndto = 0;
  wire awr, wrdy, bvalid, arr, rvalid, ack, dma_timeout, irq, oe_n, rs_n, ws_n, dout_en, rdy;
  wire [1:0] bresp, rresp, lane_n;
  wire [31:0] rdata;
  wire [15:0] rdata_q, dout, din;
  wire [3:0] ce_n;
  wire [20:0] maddr;
  int fail_count = 0;
  int cmp_count = 0;
  always #10 aclk = ~aclk;
  async_mem_ctrl async_mem_ctrl_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .req(req), .req_write(req_write), .req_dma(req_dma), .req_space(req_space),
    .req_addr(21'h000005), .req_wdata(16'hA5A5), .req_byte_en(2'h3), .ack(ack),
    .rdata_q(rdata_q), .dma_timeout(dma_timeout), .irq(irq), .chip_en_n(ce_n),
    .mem_addr(maddr), .byte_lane_n(lane_n), .output_en_n(oe_n), .read_strobe_n(rs_n),
    .write_strobe_n(ws_n), .mem_dout(dout), .mem_dout_en(dout_en), .mem_din(din),
    .mem_ready_in(rdy));
  async_mem_model async_mem_model_inst (.aclk(aclk), .chip_en_n(ce_n), .mem_addr(maddr),
    .byte_lane_n(lane_n), .output_en_n(oe_n), .read_strobe_n(rs_n), .write_strobe_n(ws_n),
    .mem_dout(dout), .mem_dout_en(dout_en), .stall(stall), .mem_din(din), .mem_ready_in(rdy));
  // Strobe widths, read strobe count and DMA time-out pulses
  always @(posedge aclk) begin
    rs_q <= rs_n;
    if (rs_q && !rs_n)
      nfall <= nfall + 1;
    if (!rs_n)
      rcnt <= rcnt + 1;
    else if (rcnt != 0) begin
      rwid <= rcnt;
      rcnt <= 0;
    end
    if (!ws_n)
      wcnt <= wcnt + 1;
    else if (wcnt != 0) begin
      wwid <= wcnt;
      wcnt <= 0;
    end
    if (dma_timeout)
      ndto <= ndto + 1;
  end
  function automatic [31:0] cfg(input [2:0] t, input [3:0] s, input [5:0] b, input [1:0] h);
    cfg = {2'h2, h, b, s, 2'h2, h, b, s, 1'b0, t};
  endfunction
  task automatic chk(input string nm, input [31:0] s, input [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input [7:0] a, input [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr)
        awv <= 1'b0;
      if (wrdy)
        wv <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr)
        arv <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic acc(input w, input dm, input [1:0] sp, output [31:0] lat);
    @(posedge aclk);
    req <= 1'b1;
    req_write <= w;
    req_dma <= dm;
    req_space <= sp;
    lat = 0;
    do begin
      @(posedge aclk);
      lat = lat + 1;
    end while (!ack && lat < 400);
    if (!ack) begin
      fail_count++;
      print_verdict();
    end
    req <= 1'b0;
    @(posedge aclk);
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #2000000;
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h20);
    chk("space0 reset", d, 32'hFFFFFFF1);
    rd(8'h0C);
    chk("limit reset", d, 32'h000000FF);
    rd(8'h7C);
    chk("unmapped resp", r, 2'h2);
    wr(8'h00, 32'h0);
    wr(8'h20, cfg(3'h1, 4'h3, 6'h04, 2'h1));
    wr(8'h24, cfg(3'h1, 4'h0, 6'h01, 2'h0));
    wr(8'h28, cfg(3'h0, 4'h3, 6'h04, 2'h1));
    wr(8'h2C, cfg(3'h2, 4'h3, 6'h04, 2'h1));
    acc(1'b1, 1'b0, 2'h0, l1);
    chk("write width", wwid, 4);
    acc(1'b0, 1'b0, 2'h0, l1);
    acc(1'b0, 1'b0, 2'h0, l2);
    chk("read data", rdata_q, 16'hA5A5);
    chk("read width", rwid, 4);
    chk("ext hold", l1 - l2, 3);
    acc(1'b0, 1'b0, 2'h1, l1);
    acc(1'b0, 1'b0, 2'h1, l2);
    chk("short setup", l1 - l2, 4);
    $display("test timing done");
    n = nfall;
    acc(1'b0, 1'b0, 2'h3, l1);
    chk("non-async pins", nfall, n);
    acc(1'b1, 1'b0, 2'h2, l1);
    rd(8'h04);
    chk("8-bit write", d, 32'h2);
    wr(8'h08, 32'h2);
    chk("irq set", irq, 1'b1);
    wr(8'h04, 32'h2);
    chk("irq clear", irq, 1'b0);
    acc(1'b0, 1'b0, 2'h2, l1);
    chk("8-bit read", nfall > n, 1'b1);
    $display("test types done");
    acc(1'b1, 1'b0, 2'h0, l1);
    acc(1'b1, 1'b0, 2'h0, l2);
    wr(8'h00, 32'h1);
    acc(1'b1, 1'b0, 2'h0, l1);
    chk("posted ack", l1 < l2, 1'b1);
    wr(8'h00, 32'h0);
    $display("test posting done");
    stall <= 8'h06;
    acc(1'b0, 1'b0, 2'h0, l1);
    chk("stretch", rwid > 4, 1'b1);
    wr(8'h0C, 32'h5);
    stall <= 8'h03;
    acc(1'b0, 1'b0, 2'h0, l1);
    acc(1'b0, 1'b0, 2'h0, l1);
    rd(8'h04);
    chk("no build-up", d[0], 1'b0);
    wr(8'h0C, 32'h3);
    stall <= 8'hFF;
    acc(1'b0, 1'b0, 2'h0, l1);
    rd(8'h10);
    chk("bus error", d[0], 1'b1);
    wr(8'h08, 32'h1);
    chk("cpu irq", irq, 1'b1);
    wr(8'h04, 32'h1);
    chk("irq off", irq, 1'b0);
    wr(8'h10, 32'h0);
    acc(1'b0, 1'b1, 2'h0, l1);
    chk("dma pulse", ndto, 1);
    rd(8'h10);
    chk("dma error", d[2], 1'b1);
    wr(8'h00, 32'h2);
    acc(1'b0, 1'b0, 2'h0, l1);
    rd(8'h04);
    chk("ignored ready", d[0], 1'b0);
    chk("no stretch", rwid, 4);
    stall <= 8'h00;
    $display("test ready done");
    print_verdict();
  end
endmodule // testbench
